// ---- hdl/lsb_bank.sv ----
// level supervisor bank with Avalon-MM registers and digital I/O routing
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lsb_defs.svh"

module lsb_bank import lsb_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic tick_i,
    input wire logic [2687:0] fb_data_i,
    input wire logic in_process_i,
    input wire logic [23:0] din_i,
    input wire logic [7:0] avm_address_i,
    input wire logic avm_read_i,
    input wire logic avm_write_i,
    input wire logic [31:0] avm_writedata_i,
    input wire logic [3:0] avm_byteenable_i,
    output logic [31:0] avm_readdata_o,
    output logic avm_waitrequest_o,
    output logic [31:0] level_flags_o,
    output logic [23:0] dout_o,
    output logic [191:0] fb_din_o,
    output logic irq_o
);
    // signal k of block f sits at bits ((f*14 + k) * 24) upward
    function automatic lsb_val_t pick(input logic [2687:0] bus,
                                      input logic [2:0] fb,
                                      input logic [4:0] src);
        logic [23:0] raw;
        raw = bus[(int'(fb) * `LSB_NUM_SIG + int'(src) - 1) * `LSB_SIG_W
                  +: `LSB_SIG_W];
        return lsb_val_t'($signed(raw));
    endfunction
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction
    function automatic logic [31:0] clamp_hyst(input logic [31:0] v);
        logic signed [31:0] s;
        s = $signed(v);
        if (s > `LSB_HYST_MAX) begin
            return `LSB_HYST_MAX;
        end
        if (s < -`LSB_HYST_MAX) begin
            return -`LSB_HYST_MAX;
        end
        return v;
    endfunction
    function automatic logic [15:0] clamp_dly(input logic [31:0] v);
        if (v > 32'(`LSB_DLY_MAX)) begin
            return `LSB_DLY_MAX;
        end
        return v[15:0];
    endfunction
    function automatic lsb_val_t ext(input logic [31:0] v);
        return lsb_val_t'($signed(v));
    endfunction

    // ---------------- bus slave and configuration ----------------
    logic [9:0] cfg_reg [32];
    logic [9:0] cfg_next [32];
    logic [31:0] level_reg [32];
    logic [31:0] level_next [32];
    logic [31:0] hyst_reg [32];
    logic [31:0] hyst_next [32];
    logic [15:0] rise_reg [32];
    logic [15:0] rise_next [32];
    logic [15:0] fall_reg [32];
    logic [15:0] fall_next [32];
    logic [6:0] dout_cfg_reg [24];
    logic [6:0] dout_cfg_next [24];
    logic [3:0] din_cfg_reg [24];
    logic [3:0] din_cfg_next [24];
    logic [31:0] mask_reg;
    logic [31:0] mask_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic wait_reg;
    logic wait_next;
    logic [31:0] status_reg;
    logic [31:0] status_next;
    logic [31:0] flag_reg;
    logic [31:0] flag_next;

    logic req;
    logic wr_en;
    logic [2:0] bank;
    logic [4:0] idx;
    logic [31:0] wd;
    assign req = avm_read_i | avm_write_i;
    // the access completes on the edge where waitrequest is seen low
    assign wr_en = avm_write_i & ~wait_reg;
    assign bank = avm_address_i[7:5];
    assign idx = avm_address_i[4:0];
    always_comb begin
        cfg_next = cfg_reg;
        level_next = level_reg;
        hyst_next = hyst_reg;
        rise_next = rise_reg;
        fall_next = fall_reg;
        dout_cfg_next = dout_cfg_reg;
        din_cfg_next = din_cfg_reg;
        mask_next = mask_reg;
        wait_next = ~(req & wait_reg);
        rdata_next = rdata_reg;
        wd = 32'h0000_0000;
        unique case (bank)
            `LSB_BANK_CFG: wd = 32'(cfg_reg[idx]);
            `LSB_BANK_LEVEL: wd = level_reg[idx];
            `LSB_BANK_HYST: wd = hyst_reg[idx];
            `LSB_BANK_RISE: wd = 32'(rise_reg[idx]);
            `LSB_BANK_FALL: wd = 32'(fall_reg[idx]);
            `LSB_BANK_DOUT: wd = (idx < 5'd24) ? 32'(dout_cfg_reg[idx])
                                               : 32'h0000_0000;
            `LSB_BANK_DIN: wd = (idx < 5'd24) ? 32'(din_cfg_reg[idx])
                                              : 32'h0000_0000;
            `LSB_BANK_CTRL: begin
                if (idx == `LSB_CTRL_STATUS) begin
                    wd = status_reg;
                end else if (idx == `LSB_CTRL_MASK) begin
                    wd = mask_reg;
                end else if (idx == `LSB_CTRL_FLAGS) begin
                    wd = flag_reg;
                end
            end
        endcase
        if (avm_read_i && wait_reg) begin
            rdata_next = wd;
        end
        // write data merged over the current contents by byte lane
        wd = merge(wd, avm_writedata_i, avm_byteenable_i);
        if (wr_en) begin
            unique case (bank)
                `LSB_BANK_CFG: cfg_next[idx] = wd[9:0];
                `LSB_BANK_LEVEL: level_next[idx] = wd;
                `LSB_BANK_HYST: hyst_next[idx] = clamp_hyst(wd);
                `LSB_BANK_RISE: rise_next[idx] = clamp_dly(wd);
                `LSB_BANK_FALL: fall_next[idx] = clamp_dly(wd);
                `LSB_BANK_DOUT: begin
                    if (idx < 5'd24) begin
                        dout_cfg_next[idx] = wd[6:0];
                    end
                end
                `LSB_BANK_DIN: begin
                    if (idx < 5'd24) begin
                        din_cfg_next[idx] = wd[3:0];
                    end
                end
                `LSB_BANK_CTRL: begin
                    if (idx == `LSB_CTRL_MASK) begin
                        mask_next = wd;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int s = 0; s < `LSB_NUM_SUP; s++) begin
                cfg_reg[s] <= 10'h000;
                level_reg[s] <= 32'h0000_0000;
                hyst_reg[s] <= `LSB_HYST_RST;
                rise_reg[s] <= 16'h0000;
                fall_reg[s] <= 16'h0000;
            end
            for (int o = 0; o < `LSB_NUM_IO; o++) begin
                dout_cfg_reg[o] <= 7'h00;
                din_cfg_reg[o] <= 4'h0;
            end
            mask_reg <= 32'h0000_0000;
            rdata_reg <= 32'h0000_0000;
            wait_reg <= 1'b1;
        end else if (ce_i) begin
            cfg_reg <= cfg_next;
            level_reg <= level_next;
            hyst_reg <= hyst_next;
            rise_reg <= rise_next;
            fall_reg <= fall_next;
            dout_cfg_reg <= dout_cfg_next;
            din_cfg_reg <= din_cfg_next;
            mask_reg <= mask_next;
            rdata_reg <= rdata_next;
            wait_reg <= wait_next;
        end
    end

    // ---------------- supervisors ----------------
    logic [31:0] above_reg;
    logic [31:0] above_next;
    logic [15:0] cnt_reg [32];
    logic [15:0] cnt_next [32];
    logic [31:0] used;
    logic [31:0] want;
    logic [31:0] w1c;

    always_comb begin
        lsb_val_t x;
        lsb_val_t hi;
        lsb_val_t lo;
        lsb_val_t h;
        logic [15:0] dly;
        x = '0;
        hi = '0;
        lo = '0;
        h = '0;
        dly = 16'h0000;
        above_next = above_reg;
        cnt_next = cnt_reg;
        for (int s = 0; s < `LSB_NUM_SUP; s++) begin
            used[s] = (cfg_reg[s][`LSB_CFG_SRC] != 5'h00) &&
                      (cfg_reg[s][`LSB_CFG_SRC] <= `LSB_SRC_MAX);
            x = used[s] ? pick(fb_data_i, cfg_reg[s][`LSB_CFG_FB],
                               cfg_reg[s][`LSB_CFG_SRC]) : '0;
            if (cfg_reg[s][`LSB_CFG_ABS] && x < 0) begin
                x = -x;
            end
            // band lies above the level for positive, below for negative
            h = ext(hyst_reg[s]);
            hi = ext(level_reg[s]) + ((h > 0) ? h : '0);
            lo = ext(level_reg[s]) + ((h < 0) ? h : '0);
            want[s] = above_reg[s] ? (x > lo) : (x > hi);
            dly = want[s] ? rise_reg[s] : fall_reg[s];
            if (!used[s]) begin
                above_next[s] = 1'b0;
                cnt_next[s] = 16'h0000;
            end else if (tick_i) begin
                if (want[s] == above_reg[s]) begin
                    cnt_next[s] = 16'h0000;
                end else if (cnt_reg[s] >= dly) begin
                    above_next[s] = want[s];
                    cnt_next[s] = 16'h0000;
                end else begin
                    cnt_next[s] = cnt_reg[s] + 16'h0001;
                end
            end
            flag_next[s] = used[s] &
                (above_next[s] ^ cfg_reg[s][`LSB_CFG_BELOW]);
        end
        // a flag change in the clearing cycle still sets its bit
        w1c = (wr_en && bank == `LSB_BANK_CTRL &&
               idx == `LSB_CTRL_STATUS) ? wd : 32'h0000_0000;
        status_next = (status_reg & ~w1c) | (flag_next ^ flag_reg);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            above_reg <= 32'h0000_0000;
            flag_reg <= 32'h0000_0000;
            status_reg <= 32'h0000_0000;
            for (int s = 0; s < `LSB_NUM_SUP; s++) begin
                cnt_reg[s] <= 16'h0000;
            end
        end else if (ce_i) begin
            above_reg <= above_next;
            flag_reg <= flag_next;
            status_reg <= status_next;
            cnt_reg <= cnt_next;
        end
    end

    // ---------------- digital I/O routing ----------------
    logic [23:0] din_s1_reg;
    logic [23:0] din_s2_reg;
    logic [23:0] dout_reg;
    logic [23:0] dout_next;
    logic [191:0] fb_din_reg;
    logic [191:0] fb_din_next;
    logic irq_reg;
    logic irq_next;

    always_comb begin
        fb_din_next = '0;
        for (int o = 0; o < `LSB_NUM_IO; o++) begin
            unique case (lsb_dout_src_t'(dout_cfg_reg[o][1:0]))
                LSB_DOUT_INPROC: dout_next[o] = in_process_i;
                LSB_DOUT_LEVEL: dout_next[o] =
                    flag_reg[dout_cfg_reg[o][`LSB_DOUT_SEL]];
                default: dout_next[o] = 1'b0;
            endcase
            if (din_cfg_reg[o][0]) begin
                fb_din_next[int'(din_cfg_reg[o][`LSB_DIN_FB]) * `LSB_NUM_IO
                            + o] = din_s2_reg[o];
            end
        end
        irq_next = |(status_reg & mask_reg);
    end

    // pins pass two stages before any routing sees them
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            din_s1_reg <= 24'h00_0000;
            din_s2_reg <= 24'h00_0000;
            dout_reg <= 24'h00_0000;
            fb_din_reg <= '0;
            irq_reg <= 1'b0;
        end else if (ce_i) begin
            din_s1_reg <= din_i;
            din_s2_reg <= din_s1_reg;
            dout_reg <= dout_next;
            fb_din_reg <= fb_din_next;
            irq_reg <= irq_next;
        end
    end

    assign avm_readdata_o = rdata_reg;
    assign avm_waitrequest_o = wait_reg;
    assign level_flags_o = flag_reg;
    assign dout_o = dout_reg;
    assign fb_din_o = fb_din_reg;
    assign irq_o = irq_reg;
    // ---------------- checks on supervisor 0 and output 0 ----------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence rise_cause_s;
        tick_i && ce_i && used[0] && want[0] && cnt_reg[0] >= rise_reg[0];
    endsequence
    sequence fall_cause_s;
        tick_i && ce_i && used[0] && !want[0] && cnt_reg[0] >= fall_reg[0];
    endsequence

    unused_off_a: assert property (
        ce_i && cfg_reg[0][`LSB_CFG_SRC] == 5'h00 |=> !flag_reg[0]
    ) else $error("unused supervisor shows a flag");
    rise_delay_a: assert property (
        $rose(above_reg[0]) |-> $past(used[0] && tick_i && want[0] &&
                                      cnt_reg[0] >= rise_reg[0])
    ) else $error("rise taken before its delay");
    fall_delay_a: assert property (
        $fell(above_reg[0]) && $past(used[0]) |->
            $past(tick_i && !want[0] && cnt_reg[0] >= fall_reg[0])
    ) else $error("fall taken before its delay");
    rise_take_a: assert property (
        rise_cause_s |=> above_reg[0]
    ) else $error("qualified rise not taken");
    fall_take_a: assert property (
        fall_cause_s |=> !above_reg[0]
    ) else $error("qualified fall not taken");
    polarity_out_a: assert property (
        $changed(above_reg[0]) && $stable(cfg_reg[0]) |->
            flag_reg[0] == (used[0] &
                (above_reg[0] ^ cfg_reg[0][`LSB_CFG_BELOW]))
    ) else $error("flag polarity wrong");
    tick_only_a: assert property (
        $changed(cnt_reg[0]) && cnt_reg[0] != 16'h0000 |-> $past(tick_i)
    ) else $error("delay counted without a tick");
    dout_inproc_a: assert property (
        ce_i && dout_cfg_reg[0][1:0] == 2'h1 |=> dout_reg[0] ==
            $past(in_process_i)
    ) else $error("in-process output mismatch");
    dout_level_a: assert property (
        ce_i && dout_cfg_reg[0][1:0] == 2'h2 |=> dout_reg[0] ==
            $past(flag_reg[dout_cfg_reg[0][`LSB_DOUT_SEL]])
    ) else $error("level output mismatch");
    dout_unused_a: assert property (
        ce_i && dout_cfg_reg[0][1:0] == 2'h0 |=> !dout_reg[0]
    ) else $error("unused output driven");

endmodule // lsb_bank
`default_nettype wire

// ---- hdl/lsb_defs.svh ----
// constants of the level supervisor bank: register map, fields, resets
//
// Function
// - thirty-two supervisors, each with its own complete setting set
// - source: unused, sum, difference, outputs 1-8, forces of inputs A-D
// - unused source makes supervisor inactive and its routed outputs off
// - normal mode: active while signed signal exceeds the level
// - absolute mode: active while signal magnitude exceeds the level
// - function block selector one to eight, default block one
// - polarity: output active above level (default) or below it
// - signed hysteresis up to 999999, default 2, band above or below
// - switch up only after staying above for the rise delay, 0 to 10.00
// - switch down only after staying below for the fall delay
// - digital output source: unused keeps it off, in-process, or level
// - in-process source drives the output exactly with that condition
// - level source: selector 1 to 32, default 1, picks the flag
// - three slots of up to eight outputs numbered 11-18, 21-28, 31-38
// - each digital input assigned to one of eight blocks unless unused
`ifndef LSB_DEFS_SVH
`define LSB_DEFS_SVH

`define LSB_NUM_SUP 32
`define LSB_NUM_FB 8
`define LSB_NUM_SIG 14
`define LSB_SIG_W 24
`define LSB_NUM_IO 24

// word addresses, bank in addr[7:5], entry in addr[4:0]
`define LSB_BANK_CFG 3'h0
`define LSB_BANK_LEVEL 3'h1
`define LSB_BANK_HYST 3'h2
`define LSB_BANK_RISE 3'h3
`define LSB_BANK_FALL 3'h4
`define LSB_BANK_DOUT 3'h5
`define LSB_BANK_DIN 3'h6
`define LSB_BANK_CTRL 3'h7
`define LSB_CTRL_STATUS 5'h00
`define LSB_CTRL_MASK 5'h01
`define LSB_CTRL_FLAGS 5'h02

// supervisor config fields
`define LSB_CFG_SRC 4:0
`define LSB_CFG_ABS 5
`define LSB_CFG_FB 8:6
`define LSB_CFG_BELOW 9
`define LSB_SRC_MAX 5'h0e
// digital output config: [1:0] source, [6:2] level index (0 = level 1)
`define LSB_DOUT_SEL 6:2
// digital input config: [0] in use, [3:1] block
`define LSB_DIN_FB 3:1

`define LSB_HYST_RST 32'h0000_0002
`define LSB_HYST_MAX 32'sd999999
`define LSB_DLY_MAX 16'h03e8

`endif

// ---- hdl/lsb_pkg.sv ----
// types of the level supervisor bank
package lsb_pkg;
    typedef enum logic [1:0] {
        LSB_DOUT_UNUSED,
        LSB_DOUT_INPROC,
        LSB_DOUT_LEVEL
    } lsb_dout_src_t;
    typedef logic signed [33:0] lsb_val_t;
endpackage

// ---- dv/lsb_far_model.sv ----
// far-side model: function blocks presenting their measured values
`timescale 1ns/1ps
`default_nettype none

module lsb_far_model (
    input wire logic clk_i,
    output logic [2687:0] fb_data_o
);
    logic [23:0] val_reg [112];
    logic pin_reg [112];

    initial begin
        for (int i = 0; i < 112; i++) begin
            pin_reg[i] = 1'b0;
        end
    end

    // untargeted signals churn every cycle so a wrong selection shows
    always @(posedge clk_i) begin
        for (int i = 0; i < 112; i++) begin
            fb_data_o[i*24 +: 24] <= pin_reg[i] ? val_reg[i]
                                                : 24'($urandom);
        end
    end

    // block f, signal k: 0 sum, 1 difference, 2..9 outputs, 10..13 forces
    task put(input int f, input int k, input logic [23:0] v);
        val_reg[f*14+k] <= v;
        pin_reg[f*14+k] <= 1'b1;
    endtask
endmodule // lsb_far_model

`default_nettype wire

// ---- dv/test_level_supervisor_bank.sv ----
// self-checking bench of the level supervisor bank
`timescale 1ns/1ps
`default_nettype none
`include "lsb_defs.svh"

module test_level_supervisor_bank;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic tick_i = 1'b0;
    logic ce_i = 1'b1;
    logic in_process_i = 1'b0;
    logic avm_read_i = 1'b0;
    logic avm_write_i = 1'b0;
    logic [7:0] avm_address_i = '0;
    logic [31:0] avm_writedata_i = '0;
    logic [3:0] avm_byteenable_i = '0;
    logic [23:0] din_i = '0;
    logic [31:0] avm_readdata_o, level_flags_o, q, chg, fe;
    logic [23:0] dout_o, de;
    logic [191:0] fb_din_o, ev;
    logic [2687:0] fb_data_i;
    logic avm_waitrequest_o, irq_o;
    int err_count = 0;
    int n_compared = 0;
    int lvl[32], hy[32], rd[32], fd[32], cnt[32], xs[32], ds[24], dl[24];
    bit ab[32], bl[32], up[32], used[32];
    int s, f;

    lsb_far_model lsb_far_model_inst (.clk_i(clk_i), .fb_data_o(fb_data_i));
    lsb_bank lsb_bank_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .tick_i(tick_i), .fb_data_i(fb_data_i), .in_process_i(in_process_i),
        .din_i(din_i), .avm_address_i(avm_address_i),
        .avm_read_i(avm_read_i), .avm_write_i(avm_write_i),
        .avm_writedata_i(avm_writedata_i),
        .avm_byteenable_i(avm_byteenable_i),
        .avm_readdata_o(avm_readdata_o),
        .avm_waitrequest_o(avm_waitrequest_o),
        .level_flags_o(level_flags_o), .dout_o(dout_o),
        .fb_din_o(fb_din_o), .irq_o(irq_o));

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    task summarize();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task chk_vec(input logic [191:0] got, input logic [191:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one bus cycle; an edge passes first so a release never meets a raise
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic [3:0] be);
        int i;
        @(posedge clk_i);
        avm_address_i <= a;
        avm_write_i <= w;
        avm_read_i <= ~w;
        avm_writedata_i <= d;
        avm_byteenable_i <= be;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (avm_waitrequest_o === 1'b0) break;
        end
        if (i == 20) begin
            err_count++;
            summarize();
        end
        q = avm_readdata_o;
        avm_read_i <= 1'b0;
        avm_write_i <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        chk_word(q, e);
    endtask

    function automatic logic [31:0] flags_exp();
        logic [31:0] e;
        for (int i = 0; i < 32; i++) begin
            e[i] = used[i] & (up[i] ^ bl[i]);
        end
        return e;
    endfunction

    // one sample tick, then the model advances every used supervisor
    task step();
        int v, lo, hi;
        tick_i <= 1'b1;
        @(posedge clk_i);
        tick_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 32; i++) begin
            if (!used[i]) continue;
            v = (ab[i] && xs[i] < 0) ? -xs[i] : xs[i];
            hi = lvl[i] + (hy[i] > 0 ? hy[i] : 0);
            lo = lvl[i] + (hy[i] < 0 ? hy[i] : 0);
            cnt[i] = (up[i] ? v <= lo : v > hi) ? cnt[i] + 1 : 0;
            if (cnt[i] > (up[i] ? fd[i] : rd[i])) begin
                up[i] = ~up[i];
                cnt[i] = 0;
                chg[i] = 1'b1;
            end
        end
        chk_word(level_flags_o, flags_exp());
    endtask

    initial begin
        void'($urandom(32'h98fc));
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdc(8'h00, 32'h0);
        rdc(8'h45, 32'h2);
        rdc(8'h61, 32'h0);
        rdc(8'h81, 32'h0);
        rdc(8'ha0, 32'h0);
        rdc(8'hc0, 32'h0);
        rdc(8'he2, 32'h0);
        wr(8'h47, 32'h000f4240);
        rdc(8'h47, 32'h000f423f);
        wr(8'h47, 32'hfff0bdc0);
        rdc(8'h47, 32'hfff0bdc1);
        wr(8'h67, 32'h000007d0);
        rdc(8'h67, 32'h000003e8);
        bus(1'b1, 8'h23, 32'h12345678, 4'h3);
        rdc(8'h23, 32'h00005678);
        wr(8'hb8, 32'h000000ff);
        rdc(8'hb8, 32'h0);
        rdc(8'hd8, 32'h0);
        $display("test registers done");
        wr(8'he1, 32'hffffffff);
        // each source code once, on its own supervisor and block signal
        for (int c = 1; c < 15; c++) begin
            s = 2 * c - 2;
            f = $urandom % 8;
            ab[s] = c % 2;
            bl[s] = (c / 2) % 2;
            lvl[s] = int'($urandom % 1600) - (ab[s] ? 0 : 800);
            hy[s] = int'($urandom % 81) - 40;
            rd[s] = $urandom % 4;
            fd[s] = $urandom % 4;
            lsb_far_model_inst.put(f, c - 1, 24'h0);
            wr({`LSB_BANK_LEVEL, 5'(s)}, 32'(lvl[s]));
            wr({`LSB_BANK_HYST, 5'(s)}, 32'(hy[s]));
            wr({`LSB_BANK_RISE, 5'(s)}, 32'(rd[s]));
            wr({`LSB_BANK_FALL, 5'(s)}, 32'(fd[s]));
            wr({`LSB_BANK_CFG, 5'(s)}, {22'h0, bl[s], 3'(f), ab[s], 5'(c)});
            used[s] = 1'b1;
            wr(8'he0, 32'hffffffff);
            chg = '0;
            repeat (24) begin
                xs[s] = int'($urandom % 2000) - 1000;
                lsb_far_model_inst.put(f, c - 1, 24'(xs[s]));
                @(posedge clk_i);
                step();
            end
            rdc(8'he0, chg);
            chk_word({31'h0, irq_o}, {31'h0, |chg});
        end
        wr(8'he1, 32'h0);
        rdc(8'he2, flags_exp());
        chk_word({31'h0, irq_o}, 32'h0);
        $display("test supervisors done");
        for (int n = 0; n < 24; n++) begin
            ds[n] = n == 0 ? 2 : $urandom % 4;
            dl[n] = n == 0 ? 2 : 2 * (1 + $urandom % 14);
            wr({`LSB_BANK_DOUT, 5'(n)}, {25'h0, 5'(dl[n]), 2'(ds[n])});
        end
        for (int k = 0; k < 3; k++) begin
            if (k == 1) begin
                wr({`LSB_BANK_DOUT, 5'd0}, 32'h0000_0001);
                ds[0] = 1;
            end
            if (k == 2) begin
                wr({`LSB_BANK_CFG, 5'd2}, 32'h0000000f);
                used[2] = 1'b0;
            end
            in_process_i <= k[0];
            repeat (3) @(posedge clk_i);
            fe = flags_exp();
            for (int n = 0; n < 24; n++) begin
                de[n] = (ds[n] == 1 && k[0]) || (ds[n] == 2 && fe[dl[n]]);
            end
            chk_vec({168'h0, dout_o}, {168'h0, de});
            chk_word(level_flags_o, fe);
        end
        // a low clock enable must freeze the in-process output
        ce_i <= 1'b0;
        in_process_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk_word({31'h0, dout_o[0]}, 32'h0000_0000);
        ce_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk_word({31'h0, dout_o[0]}, 32'h0000_0001);
        $display("test outputs done");
        for (int n = 0; n < 24; n++) begin
            ds[n] = $urandom % 16;
            wr({`LSB_BANK_DIN, 5'(n)}, 32'(ds[n]));
        end
        repeat (2) begin
            din_i <= 24'($urandom);
            repeat (6) @(posedge clk_i);
            ev = '0;
            for (int n = 0; n < 24; n++) begin
                ev[ds[n] / 2 * 24 + n] = ds[n] % 2 && din_i[n];
            end
            chk_vec(fb_din_o, ev);
        end
        $display("test inputs done");
        summarize();
    end
endmodule // test_level_supervisor_bank

`default_nettype wire
